// ==== core/e1rx_regs.vh ====
// Register offsets, field positions, reset values and timing counts
// for the E1 receive line input selector.
// Assumes an AXI4-Lite master with 8-bit byte addresses and 32-bit data.
`ifndef E1RX_REGS_VH
`define E1RX_REGS_VH

`define E1RX_ADDR_W 8
`define E1RX_CFG_OFS 8'h00
`define E1RX_STAT_OFS 8'h04
`define E1RX_CNT_OFS 8'h08

`define E1RX_CFG_SINGLE_BIT 0
`define E1RX_CFG_NRZ_BIT 1
`define E1RX_CFG_FALL_BIT 2
`define E1RX_CFG_ANALOG_BIT 3
`define E1RX_CFG_W 4
`define E1RX_CFG_RST 4'h0

`define E1RX_RESP_OKAY 2'h0
`define E1RX_RESP_SLVERR 2'h2

`define E1RX_CLK_PERIOD_NS 8
`define E1RX_BIT_PERIOD_NS 488
`define E1RX_BIT_CYC (`E1RX_BIT_PERIOD_NS / `E1RX_CLK_PERIOD_NS)
`define E1RX_PH_W 6
`define E1RX_PH_LAST (`E1RX_BIT_CYC - 1)
`define E1RX_PH_HALF (`E1RX_BIT_CYC / 2)
`define E1RX_PH_MARK (`E1RX_BIT_CYC / 4)

`endif

// ==== core/e1rx_input_select.v ====
// Receive line input stage: dual-rail RZ/NRZ or single-rail input, sampling on the
// line clock, clock recovery from rail pulses, and sliced pulse output when analog is on.
// Assumes all line-side inputs are asynchronous to clk_sys_in and an AXI4-Lite master.
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "e1rx_regs.vh"

module e1rx_input_select (
    input wire clk_sys_in, // System clock, 125 MHz
    input wire rst_n_in, // Asynchronous reset, active low
    input wire rx_pos_rail_in, // Positive rail pin, input side
    input wire rx_neg_rail_in, // Negative rail pin, input side
    output wire sliced_pos_pulse_out, // Positive rail pin, output side
    output wire sliced_neg_pulse_out, // Negative rail pin, output side
    output wire pos_rail_oe_out, // Positive rail pin drive enable
    output wire neg_rail_oe_out, // Negative rail pin drive enable
    input wire slicer_pos_in, // Analog slicer positive comparator
    input wire slicer_neg_in, // Analog slicer negative comparator
    input wire rx_line_clk_in, // External recovered line clock
    output wire recovered_clk_out, // Recovered receive clock
    output wire rx_bit_pos_out, // Sampled positive rail or data
    output wire rx_bit_neg_out, // Sampled negative rail or violation
    output wire rx_bit_valid_out, // One-cycle strobe per received bit
    input wire [`E1RX_ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire s_axi_awvalid, // Write address valid
    output wire s_axi_awready, // Write address ready
    input wire [31:0] s_axi_wdata, // Write data
    input wire [3:0] s_axi_wstrb, // Write byte strobes
    input wire s_axi_wvalid, // Write data valid
    output wire s_axi_wready, // Write data ready
    output wire [1:0] s_axi_bresp, // Write response
    output wire s_axi_bvalid, // Write response valid
    input wire s_axi_bready, // Write response ready
    input wire [`E1RX_ADDR_W-1:0] s_axi_araddr, // Read address
    input wire s_axi_arvalid, // Read address valid
    output wire s_axi_arready, // Read address ready
    output wire [31:0] s_axi_rdata, // Read data
    output wire [1:0] s_axi_rresp, // Read response
    output wire s_axi_rvalid, // Read response valid
    input wire s_axi_rready // Read response ready
);

    localparam IDX_POS = 0;
    localparam IDX_NEG = 1;
    localparam IDX_LCLK = 2;
    localparam IDX_APOS = 3;
    localparam IDX_ANEG = 4;
    // The re-centre phase is cut to the counter width on purpose; it always fits.
    localparam [31:0] PH_MARK_FULL = `E1RX_PH_MARK;

    wire [4:0] async_w;
    reg [4:0] sync_s1_q;
    reg [4:0] sync_s2_q;
    reg lclk_s3_q;
    reg [`E1RX_CFG_W-1:0] cfg_q;
    reg [`E1RX_PH_W-1:0] phase_q;
    reg [`E1RX_PH_W-1:0] phase_d;
    reg mark_prev_q;
    reg acc_pos_q;
    reg acc_neg_q;
    reg bit_pos_q;
    reg bit_neg_q;
    reg bit_valid_q;
    reg rec_clk_q;
    reg sl_pos_q;
    reg sl_neg_q;
    reg oe_q;
    reg [15:0] bit_cnt_q;
    reg aw_rdy_q;
    reg w_rdy_q;
    reg aw_have_q;
    reg w_have_q;
    reg [`E1RX_ADDR_W-1:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg bvalid_q;
    reg [1:0] bresp_q;
    reg ar_rdy_q;
    reg rvalid_q;
    reg [1:0] rresp_q;
    reg [31:0] rdata_q;

    assign async_w = {slicer_neg_in, slicer_pos_in, rx_line_clk_in, rx_neg_rail_in,
        rx_pos_rail_in};

    // Every line-side input is resynchronised; only the second stage is read.
    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : g_sync
            always @(posedge clk_sys_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    sync_s1_q[g] <= 1'b0;
                    sync_s2_q[g] <= 1'b0;
                end else begin
                    sync_s1_q[g] <= async_w[g];
                    sync_s2_q[g] <= sync_s1_q[g];
                end
            end
        end
    endgenerate

    wire cfg_single = cfg_q[`E1RX_CFG_SINGLE_BIT];
    wire cfg_nrz = cfg_q[`E1RX_CFG_NRZ_BIT];
    wire cfg_fall = cfg_q[`E1RX_CFG_FALL_BIT];
    wire cfg_analog = cfg_q[`E1RX_CFG_ANALOG_BIT];

    // Pulse-driven recovery serves both the RZ rails and the slicer pulses.
    wire rz_path = cfg_analog | (~cfg_single & ~cfg_nrz);
    wire src_pos = cfg_analog ? sync_s2_q[IDX_APOS] : sync_s2_q[IDX_POS];
    wire src_neg = cfg_analog ? sync_s2_q[IDX_ANEG] : sync_s2_q[IDX_NEG];
    wire mark = src_pos | src_neg;
    wire mark_rise = mark & ~mark_prev_q;
    wire ph_wrap = (phase_q == `E1RX_PH_LAST);

    wire lclk_rise = sync_s2_q[IDX_LCLK] & ~lclk_s3_q;
    wire lclk_fall = ~sync_s2_q[IDX_LCLK] & lclk_s3_q;
    wire lclk_take = cfg_fall ? lclk_fall : lclk_rise;

    // A pulse re-centres the bit cell so that a run of zeros keeps the
    // clock running at the nominal rate; every pulse rise loads the phase to a quarter bit, whatever its offset.
    always @* begin
        phase_d = phase_q + 6'h01;
        if (mark_rise) begin
            phase_d = PH_MARK_FULL[`E1RX_PH_W-1:0];
        end else if (ph_wrap) begin
            phase_d = 6'h00;
        end
    end

    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lclk_s3_q <= 1'b0;
            phase_q <= 6'h00;
            mark_prev_q <= 1'b0;
            acc_pos_q <= 1'b0;
            acc_neg_q <= 1'b0;
            bit_pos_q <= 1'b0;
            bit_neg_q <= 1'b0;
            bit_valid_q <= 1'b0;
            rec_clk_q <= 1'b0;
            sl_pos_q <= 1'b0;
            sl_neg_q <= 1'b0;
            oe_q <= 1'b0;
            bit_cnt_q <= 16'h0000;
        end else begin
            lclk_s3_q <= sync_s2_q[IDX_LCLK];
            phase_q <= phase_d;
            mark_prev_q <= mark;
            bit_valid_q <= 1'b0;
            // A mark seen in the wrap cycle is kept for the next cell.
            if (ph_wrap) begin
                acc_pos_q <= src_pos;
                acc_neg_q <= src_neg;
            end else begin
                acc_pos_q <= acc_pos_q | src_pos;
                acc_neg_q <= acc_neg_q | src_neg;
            end
            if (rz_path) begin
                rec_clk_q <= (phase_q < `E1RX_PH_HALF);
                if (ph_wrap) begin
                    bit_pos_q <= acc_pos_q | src_pos;
                    bit_neg_q <= acc_neg_q | src_neg;
                    bit_valid_q <= 1'b1;
                end
            end else begin
                rec_clk_q <= sync_s2_q[IDX_LCLK];
                if (lclk_take) begin
                    // In single-rail form the pos pin is data, the neg pin violation.
                    bit_pos_q <= sync_s2_q[IDX_POS];
                    bit_neg_q <= sync_s2_q[IDX_NEG];
                    bit_valid_q <= 1'b1;
                end
            end
            if (bit_valid_q) begin
                bit_cnt_q <= bit_cnt_q + 16'h0001;
            end
            oe_q <= cfg_analog;
            sl_pos_q <= cfg_analog & sync_s2_q[IDX_APOS];
            sl_neg_q <= cfg_analog & sync_s2_q[IDX_ANEG];
        end
    end

    // AXI4-Lite slave: address and data are taken in either order.
    wire aw_hs = s_axi_awvalid & aw_rdy_q;
    wire w_hs = s_axi_wvalid & w_rdy_q;
    wire do_write = aw_have_q & w_have_q & ~bvalid_q;
    wire ar_hs = s_axi_arvalid & ar_rdy_q;

    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            aw_rdy_q <= 1'b1;
            w_rdy_q <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `E1RX_RESP_OKAY;
            cfg_q <= `E1RX_CFG_RST;
        end else begin
            if (aw_hs) begin
                aw_rdy_q <= 1'b0;
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_rdy_q <= 1'b0;
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                if (aw_addr_q == `E1RX_CFG_OFS) begin
                    bresp_q <= `E1RX_RESP_OKAY;
                    if (w_strb_q[0]) begin
                        cfg_q <= w_data_q[`E1RX_CFG_W-1:0];
                    end
                end else if (aw_addr_q == `E1RX_STAT_OFS || aw_addr_q == `E1RX_CNT_OFS) begin
                    bresp_q <= `E1RX_RESP_OKAY;
                end else begin
                    bresp_q <= `E1RX_RESP_SLVERR;
                end
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
                aw_rdy_q <= 1'b1;
                w_rdy_q <= 1'b1;
            end
        end
    end

    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ar_rdy_q <= 1'b1;
            rvalid_q <= 1'b0;
            rresp_q <= `E1RX_RESP_OKAY;
            rdata_q <= 32'h00000000;
        end else begin
            if (ar_hs) begin
                ar_rdy_q <= 1'b0;
                rvalid_q <= 1'b1;
                rresp_q <= `E1RX_RESP_OKAY;
                case (s_axi_araddr)
                    `E1RX_CFG_OFS: rdata_q <= {28'h0000000, cfg_q};
                    `E1RX_STAT_OFS: rdata_q <= {26'h0, oe_q, rz_path,
                        rec_clk_q, sync_s2_q[IDX_LCLK], bit_neg_q, bit_pos_q};
                    `E1RX_CNT_OFS: rdata_q <= {16'h0000, bit_cnt_q};
                    default: begin
                        rdata_q <= 32'h00000000;
                        rresp_q <= `E1RX_RESP_SLVERR;
                    end
                endcase
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
                ar_rdy_q <= 1'b1;
            end
        end
    end

    assign sliced_pos_pulse_out = sl_pos_q;
    assign sliced_neg_pulse_out = sl_neg_q;
    assign pos_rail_oe_out = oe_q;
    assign neg_rail_oe_out = oe_q;
    assign recovered_clk_out = rec_clk_q;
    assign rx_bit_pos_out = bit_pos_q;
    assign rx_bit_neg_out = bit_neg_q;
    assign rx_bit_valid_out = bit_valid_q;
    assign s_axi_awready = aw_rdy_q;
    assign s_axi_wready = w_rdy_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_arready = ar_rdy_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rvalid = rvalid_q;

endmodule // e1rx_input_select

// ==== verification/e1rx_props.sv ====
// Port checker for the E1 receive input selector.
// Bound onto e1rx_input_select; sees only its ports.
`timescale 1ns/10ps
module e1rx_props (
    input wire clk_sys_in, // clock
    input wire rst_n_in, // reset
    input wire pos_rail_oe_out, // pos oe
    input wire neg_rail_oe_out, // neg oe
    input wire sliced_pos_pulse_out, // pos out
    input wire sliced_neg_pulse_out, // neg out
    input wire slicer_pos_in, // pos slicer
    input wire slicer_neg_in, // neg slicer
    input wire rx_bit_valid_out, // bit strobe
    input wire s_axi_awvalid, // aw valid
    input wire s_axi_awready, // aw ready
    input wire s_axi_wvalid, // w valid
    input wire s_axi_wready, // w ready
    input wire s_axi_bvalid, // b valid
    input wire s_axi_bready // b ready
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence analog_on;
        pos_rail_oe_out && $past(pos_rail_oe_out, 3);
    endsequence
    AST_OE_PAIR: assert property (pos_rail_oe_out == neg_rail_oe_out)
        else $error("enables differ");
    AST_SLICE_POS: assert property (analog_on |->
        sliced_pos_pulse_out == $past(slicer_pos_in, 3)) else $error("pos slice");
    AST_SLICE_NEG: assert property (analog_on |->
        sliced_neg_pulse_out == $past(slicer_neg_in, 3)) else $error("neg slice");
    AST_SLICE_IDLE: assert property (!pos_rail_oe_out && !$past(pos_rail_oe_out) |->
        !sliced_pos_pulse_out && !sliced_neg_pulse_out) else $error("slice idle");
    AST_VALID_ONE: assert property (rx_bit_valid_out |=> !rx_bit_valid_out)
        else $error("strobe long");
    AST_WR_RESP: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("no bvalid");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid drop");
    AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("aw open");
endmodule // e1rx_props

// ==== verification/e1rx_line_model.sv ====
// Line receiver model driving the rail pins and line clock.
// Bench sets waveform and edge to match the device.
`timescale 1ns/10ps
module e1rx_line_model (
    input wire logic rz_mode_in, // RZ rails
    input wire logic fall_edge_in, // falling sample
    input wire logic release_in, // device drives
    input wire logic pos_bit_in, // next pos
    input wire logic neg_bit_in, // next neg
    output logic line_clk_out, // line clock
    output wire logic pos_out, // pos rail
    output wire logic neg_out // neg rail
);
    logic p_q = 1'h0;
    logic n_q = 1'h0;
    // A released pin shows the inverse so a stale level cannot pass.
    assign pos_out = release_in ^ p_q;
    assign neg_out = release_in ^ n_q;
    initial begin
        line_clk_out = 1'h0;
        #3;
        forever begin
            if (rz_mode_in) begin
                line_clk_out = 1'h0;
                {p_q, n_q} = {pos_bit_in, neg_bit_in};
                #244;
                {p_q, n_q} = 2'h0;
                #244;
            end else begin
                // Data moves on the edge opposite the sampling one.
                line_clk_out = 1'h1;
                if (fall_edge_in) {p_q, n_q} = {pos_bit_in, neg_bit_in};
                #80;
                line_clk_out = 1'h0;
                if (!fall_edge_in) {p_q, n_q} = {pos_bit_in, neg_bit_in};
                #80;
            end
        end
    end
endmodule // e1rx_line_model

// ==== verification/tb_e1rx_input_select.sv ====
// Self-checking bench for the E1 receive input selector.
// Line model feeds the rails; this module is the AXI4-Lite master.
`timescale 1ns/10ps
`include "e1rx_regs.vh"
module tb_e1rx_input_select;
    logic clk_sys_in = 1'h0;
    logic rst_n_in = 1'h0;
    logic [3:0] rnd = 4'h0;
    logic [3:0] msk = 4'h0;
    logic [2:0] lh = 3'h0;
    logic [7:0] awa = 8'h0, ara = 8'h0;
    logic [31:0] wd = 32'h0;
    logic aw = 0, w = 0, br = 0, ar = 0, rr = 0, rz = 0, fall = 0, sb = 0, cnt = 0;
    wire awr, wr, bvl, arr, rvl, sp, sn, poe, noe, lc, mp, mn, rc, bp, bn, vld;
    wire [1:0] bre, rre;
    wire [31:0] rd;
    wire rp = poe ? sp : mp;
    wire rn = noe ? sn : mn;
    int num_errors = 0, n_tests = 0, cyc = 0, seed = 32'hD1E2, mk = 0, got = 0;
    logic [1:0] q[$];
    logic [3:0] md[6] = '{4'h2, 4'h6, 4'h1, 4'h5, 4'h3, 4'h7};
    e1rx_input_select u_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .rx_pos_rail_in(rp), .rx_neg_rail_in(rn), .sliced_pos_pulse_out(sp),
        .sliced_neg_pulse_out(sn), .pos_rail_oe_out(poe), .neg_rail_oe_out(noe),
        .slicer_pos_in(rnd[3]), .slicer_neg_in(rnd[2]), .rx_line_clk_in(lc),
        .recovered_clk_out(rc), .rx_bit_pos_out(bp), .rx_bit_neg_out(bn),
        .rx_bit_valid_out(vld), .s_axi_awaddr(awa), .s_axi_awvalid(aw), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(w), .s_axi_wready(wr),
        .s_axi_bresp(bre), .s_axi_bvalid(bvl), .s_axi_bready(br), .s_axi_araddr(ara),
        .s_axi_arvalid(ar), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rre),
        .s_axi_rvalid(rvl), .s_axi_rready(rr));
    e1rx_line_model u_line (.rz_mode_in(rz), .fall_edge_in(fall), .release_in(poe),
        .pos_bit_in(rnd[1]), .neg_bit_in(rnd[0]), .line_clk_out(lc), .pos_out(mp), .neg_out(mn));
    initial forever #4 clk_sys_in = ~clk_sys_in;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Write sends d; read expects d. Ready for the answer comes at random.
    task automatic axi(input bit w_op, input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] e);
        int n;
        n = 0;
        awa <= a;
        ara <= a;
        wd <= d;
        {aw, w, ar} <= {w_op, w_op, !w_op};
        while (n < 99) begin
            @(posedge clk_sys_in);
            n++;
            if (aw && awr) aw <= 1'h0;
            if (w && wr) w <= 1'h0;
            if (ar && arr) ar <= 1'h0;
            if ((br && bvl) || (rr && rvl)) begin
                chk(w_op ? bre : rre, e);
                if (!w_op) chk(rd, d);
                {br, rr} <= 2'h0;
                n = 200;
            end else if ($random(seed) & 1) {br, rr} <= {w_op, !w_op};
        end
        if (n == 99) chk(0, 1);
    endtask
    always @(posedge lc) if (sb && !fall) q.push_back({rp, rn});
    always @(negedge lc) if (sb && fall) q.push_back({rp, rn});
    always @(posedge mp) if (cnt) mk++;
    always @(posedge clk_sys_in) begin
        rnd <= 4'($random(seed)) & msk;
        cyc <= cyc + 1;
        lh <= {lh[1:0], lc};
        if (sb) chk(rc, lh[2]);
        if (vld && q.size() > 0) chk({bp, bn}, q.pop_front());
        if (vld && bp && cnt) got <= got + 1;
        if (cyc == 40000) begin
            num_errors++;
            complete_run();
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys_in);
        rst_n_in <= 1'h1;
        @(posedge clk_sys_in);
        axi(1'h0, `E1RX_CFG_OFS, `E1RX_CFG_RST, `E1RX_RESP_OKAY);
        axi(1'h0, 8'h0C, 32'h0, `E1RX_RESP_SLVERR);
        axi(1'h1, 8'h0C, 32'hF, `E1RX_RESP_SLVERR);
        axi(1'h0, `E1RX_CFG_OFS, 32'h0, 2'h0);
        $display("test registers done");
        foreach (md[i]) begin
            axi(1'h1, `E1RX_CFG_OFS, md[i], 2'h0);
            axi(1'h0, `E1RX_CFG_OFS, md[i], 2'h0);
            fall = md[i][`E1RX_CFG_FALL_BIT];
            msk <= 4'h3;
            repeat (100) @(posedge clk_sys_in);
            sb = 1;
            repeat (800) @(posedge clk_sys_in);
            sb = 0;
            repeat (20) @(posedge clk_sys_in);
            chk(q.size(), 0);
            q.delete();
            $display("test mode %h done", md[i]);
        end
        axi(1'h1, `E1RX_CFG_OFS, 32'h0, 2'h0);
        rz = 1;
        msk <= 4'h0;
        repeat (300) @(posedge clk_sys_in);
        cnt = 1;
        msk <= 4'h3;
        repeat (2440) @(posedge clk_sys_in);
        msk <= 4'h0;
        repeat (300) @(posedge clk_sys_in);
        cnt = 0;
        chk(got, mk);
        $display("test rz done");
        rz = 0;
        axi(1'h1, `E1RX_CFG_OFS, 32'h8, 2'h0);
        msk <= 4'hC;
        repeat (200) @(posedge clk_sys_in);
        chk({poe, noe}, 2'h3);
        axi(1'h1, `E1RX_CFG_OFS, 32'h0, 2'h0);
        repeat (200) @(posedge clk_sys_in);
        chk({poe, noe}, 2'h0);
        $display("test analog done");
        complete_run();
    end
endmodule // tb_e1rx_input_select
bind e1rx_input_select e1rx_props u_props (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .pos_rail_oe_out(pos_rail_oe_out), .neg_rail_oe_out(neg_rail_oe_out),
    .sliced_pos_pulse_out(sliced_pos_pulse_out), .sliced_neg_pulse_out(sliced_neg_pulse_out),
    .slicer_pos_in(slicer_pos_in), .slicer_neg_in(slicer_neg_in),
    .rx_bit_valid_out(rx_bit_valid_out), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));
